// ### irq_accept_ctrl.sv
// Interrupt acceptance, arbitration and save/vector sequencing.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
module irq_accept_ctrl
    import irq_accept_pkg::*;
#(
    parameter int          N_SRC           = 24,
    parameter logic [15:0] NMI_VECTOR      = 16'h0004,
    parameter logic [15:0] SRC_VECTOR_BASE = 16'h0006
) (
    // Clock, reset and enable.
    input  wire logic             mclk,
    input  wire logic             arst_n,
    input  wire logic             ce,
    // External interrupt pins.
    input  wire logic [2:0]       ext_irq_pin,
    // Sources: events, mask and priority flags, request flags.
    input  wire logic [N_SRC-1:0] src_event,
    input  wire logic [N_SRC-1:0] mask_flag,
    input  wire logic [N_SRC-1:0] priority_flag,
    input  wire logic             nmi_event,
    output logic      [N_SRC-1:0] request_flag,
    // Edge select register access.
    input  wire sfr_req_t         sfr,
    output logic      [7:0]       sfr_rdata,
    // Core sequencer side.
    input  wire core_cmd_t        core_cmd,
    input  wire psw_wr_t          psw_wr,
    output logic      [7:0]       processor_status_word,
    input  wire logic             seq_ack,
    output seq_out_t              seq,
    output logic      [7:0]       push_data,
    output logic      [15:0]      vector_addr,
    output logic                  nmi_in_service
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations.
    logic [2:0]       rising_edge_select_reg;
    logic [2:0]       falling_edge_select_reg;
    logic [2:0]       ext_edge;
    logic [7:0]       psw_reg;
    logic [N_SRC-1:0] req_reg;
    logic [N_SRC-1:0] cand_hi;
    logic [N_SRC-1:0] cand_lo;
    logic [N_SRC-1:0] acc_clear;
    logic             nmi_pend_reg;
    logic             nmi_active_reg;
    logic             hold_reg;
    logic             boundary;
    logic             hi_valid;
    logic             lo_valid;
    logic [4:0]       hi_idx;
    logic [4:0]       lo_idx;
    logic             start;
    logic [1:0]       start_kind;
    logic [4:0]       start_idx;
    logic             start_prio;
    seq_state_t       state_reg;
    seq_state_t       state_next;
    logic [1:0]       kind_reg;
    logic [4:0]       idx_reg;
    logic             prio_reg;
    logic [7:0]       sfr_rdata_reg;

    // Lowest set index wins; used for both priority levels.
    function automatic logic [5:0] first_set(input logic [N_SRC-1:0] v);
        logic [5:0] r;
        r = '0;
        for (int i = N_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, i[4:0]};
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Edge selection registers and pin edge detection.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rising_edge_select_reg  <= EDGE_SEL_RESET[2:0];
            falling_edge_select_reg <= EDGE_SEL_RESET[2:0];
        end else if (ce && sfr.wr) begin
            // Byte writes use a full mask, bit writes a single-bit mask.
            if (sfr.addr == RISE_SEL_ADDR) begin
                rising_edge_select_reg <= (rising_edge_select_reg & ~sfr.wmask[2:0])
                                        | (sfr.wdata[2:0] & sfr.wmask[2:0]);
            end
            if (sfr.addr == FALL_SEL_ADDR) begin
                falling_edge_select_reg <= (falling_edge_select_reg & ~sfr.wmask[2:0])
                                         | (sfr.wdata[2:0] & sfr.wmask[2:0]);
            end
        end
    end

    // Read data is registered; bits 7..3 and unmapped addresses read zero.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sfr_rdata_reg <= 8'h00;
        end else if (ce && sfr.rd) begin
            case (sfr.addr)
                RISE_SEL_ADDR: sfr_rdata_reg <= {5'h00, rising_edge_select_reg};
                FALL_SEL_ADDR: sfr_rdata_reg <= {5'h00, falling_edge_select_reg};
                default:       sfr_rdata_reg <= 8'h00;
            endcase
        end
    end
    assign sfr_rdata = sfr_rdata_reg;

    ext_edge_detect #(
        .N (EXT_PINS)
    ) u_edge (
        .mclk       (mclk),
        .arst_n     (arst_n),
        .ce         (ce),
        .pin        (ext_irq_pin),
        .rise_sel   (rising_edge_select_reg),
        .fall_sel   (falling_edge_select_reg),
        .edge_pulse (ext_edge)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Request flags: set on event, cleared on acceptance; set wins the clash.
    assign acc_clear = (start && start_kind == KIND_MASK)
                     ? (N_SRC'(1) << start_idx) : '0;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            req_reg <= '0;
        end else if (ce) begin
            req_reg <= (req_reg & ~acc_clear) | src_event
                     | {{(N_SRC - EXT_PINS){1'b0}}, ext_edge};
        end
    end
    assign request_flag = req_reg;

    // Non-maskable pending latch collapses repeats; service flag ends on return.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            nmi_pend_reg   <= 1'b0;
            nmi_active_reg <= 1'b0;
        end else if (ce) begin
            if (nmi_event) begin
                nmi_pend_reg <= 1'b1;
            end else if (start && start_kind == KIND_NMI) begin
                nmi_pend_reg <= 1'b0;
            end
            if (start && start_kind == KIND_NMI) begin
                nmi_active_reg <= 1'b1;
            end else if (core_cmd.interrupt_return_insn) begin
                nmi_active_reg <= 1'b0;
            end
        end
    end
    assign nmi_in_service = nmi_active_reg;

    // After a return, one main-program instruction runs before any acceptance.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            hold_reg <= 1'b0;
        end else if (ce) begin
            if (core_cmd.interrupt_return_insn || core_cmd.break_return_insn) begin
                hold_reg <= 1'b1;
            end else if (core_cmd.insn_done) begin
                hold_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration at an instruction boundary, only while the sequence is idle.
    assign boundary = ce && core_cmd.insn_done && state_reg == S_IDLE && !hold_reg
                    && !core_cmd.interrupt_return_insn && !core_cmd.break_return_insn;
    // Maskable candidates: flag set, mask clear, enable set, none under NMI.
    assign cand_hi = req_reg & ~mask_flag & ~priority_flag
                   & {N_SRC{psw_reg[PSW_IE_BIT] & ~nmi_active_reg}};
    assign cand_lo = req_reg & ~mask_flag & priority_flag
                   & {N_SRC{psw_reg[PSW_IE_BIT] & psw_reg[PSW_ISP_BIT]
                            & ~nmi_active_reg}};
    assign {hi_valid, hi_idx} = first_set(cand_hi);
    assign {lo_valid, lo_idx} = first_set(cand_lo);

    // Break is the instruction itself; otherwise NMI outranks maskables.
    always_comb begin
        start      = 1'b0;
        start_kind = KIND_MASK;
        start_idx  = '0;
        start_prio = 1'b0;
        if (ce && core_cmd.break_insn && state_reg == S_IDLE) begin
            start      = 1'b1;
            start_kind = KIND_BRK;
        end else if (boundary && nmi_pend_reg && !nmi_active_reg) begin
            start      = 1'b1;
            start_kind = KIND_NMI;
        end else if (boundary && hi_valid) begin
            start      = 1'b1;
            start_idx  = hi_idx;
        end else if (boundary && lo_valid) begin
            start      = 1'b1;
            start_idx  = lo_idx;
            start_prio = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequence: optional low-priority wait, push status, push counter, vector.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (start) begin
                    state_next = start_prio ? S_PRIO : S_PSW;
                end
            end
            S_PRIO: state_next = S_PSW;
            S_PSW:  state_next = seq_ack ? S_PC : S_PSW;
            S_PC:   state_next = seq_ack ? S_VEC : S_PC;
            S_VEC:  state_next = seq_ack ? S_IDLE : S_VEC;
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= S_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // Accepted source is latched for the whole sequence.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            kind_reg <= KIND_MASK;
            idx_reg  <= '0;
            prio_reg <= 1'b0;
        end else if (start) begin
            kind_reg <= start_kind;
            idx_reg  <= start_idx;
            prio_reg <= start_prio;
        end
    end

    // Pushed status snapshot and vector address are registered data.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            push_data   <= 8'h00;
            vector_addr <= 16'h0000;
        end else if (ce && state_reg == S_IDLE && start) begin
            push_data <= psw_reg & PSW_IMPL_MASK;
            case (start_kind)
                KIND_NMI: vector_addr <= NMI_VECTOR;
                KIND_BRK: vector_addr <= BRK_VECTOR;
                default:  vector_addr <= SRC_VECTOR_BASE + {10'h000, start_idx, 1'b0};
            endcase
        end
    end

    assign seq.busy     = state_reg != S_IDLE;
    assign seq.push_psw = state_reg == S_PSW;
    assign seq.push_pc  = state_reg == S_PC;
    assign seq.load_vec = state_reg == S_VEC;

    ////////////////////////////////////////////////////////////////////////////
    // Status word: acceptance updates, then core writes, then enable/disable.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            psw_reg <= PSW_RESET;
        end else if (ce) begin
            if (state_reg == S_PC && seq_ack) begin
                psw_reg[PSW_IE_BIT] <= 1'b0;
                if (kind_reg == KIND_NMI) begin
                    psw_reg[PSW_ISP_BIT] <= 1'b0;
                end else if (kind_reg == KIND_MASK) begin
                    psw_reg[PSW_ISP_BIT] <= prio_reg;
                end
            end else if (psw_wr.we) begin
                // Byte, bit, pop and return restores all arrive here.
                psw_reg <= ((psw_reg & ~psw_wr.mask) | (psw_wr.data & psw_wr.mask))
                         & PSW_IMPL_MASK;
            end else if (core_cmd.ei) begin
                psw_reg[PSW_IE_BIT] <= 1'b1;
            end else if (core_cmd.di) begin
                psw_reg[PSW_IE_BIT] <= 1'b0;
            end
        end
    end
    assign processor_status_word = psw_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    chk_edge_sets_flag: assert property (@(posedge mclk) disable iff (!arst_n)
        (|ext_edge) |=> ((req_reg[2:0] & $past(ext_edge)) == $past(ext_edge)))
        else $error("edge did not set request flag");

    chk_mask_gates_accept: assert property (@(posedge mclk) disable iff (!arst_n)
        (start && start_kind == KIND_MASK)
        |-> (psw_reg[PSW_IE_BIT] && !mask_flag[start_idx] && req_reg[start_idx]))
        else $error("maskable accepted without enable");

    chk_low_blocked: assert property (@(posedge mclk) disable iff (!arst_n)
        (start && start_kind == KIND_MASK && priority_flag[start_idx])
        |-> psw_reg[PSW_ISP_BIT])
        else $error("low priority accepted in high service");

    chk_nmi_outranks: assert property (@(posedge mclk) disable iff (!arst_n)
        (boundary && !core_cmd.break_insn && nmi_pend_reg && !nmi_active_reg)
        |-> (start && start_kind == KIND_NMI))
        else $error("pending NMI not taken first");

    chk_low_extra_clock: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && state_reg == S_IDLE && start && start_prio)
        |=> state_reg == S_PRIO ##1 (!ce || state_reg == S_PSW))
        else $error("low priority wait missing");

    chk_isp_copied: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && state_reg == S_PC && seq_ack && kind_reg == KIND_MASK)
        |=> (!psw_reg[PSW_IE_BIT] && psw_reg[PSW_ISP_BIT] == $past(prio_reg)))
        else $error("status flags wrong after maskable accept");

    chk_brk_vector: assert property (@(posedge mclk) disable iff (!arst_n)
        (state_reg == S_VEC && kind_reg == KIND_BRK) |-> vector_addr == 16'h003E)
        else $error("break vector wrong");

    chk_hold_after_ret: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && core_cmd.insn_done && (hold_reg || core_cmd.interrupt_return_insn || core_cmd.break_return_insn))
        |-> (!start || start_kind == KIND_BRK))
        else $error("accepted before one main instruction");

    chk_enable_insn: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && core_cmd.ei && !psw_wr.we && !(state_reg == S_PC && seq_ack))
        |=> psw_reg[PSW_IE_BIT])
        else $error("enable instruction did not set flag");
endmodule // irq_accept_ctrl

// ### irq_accept_pkg.sv
// Shared constants and carrier types for the interrupt acceptance block.
package irq_accept_pkg;
    // Edge select register byte addresses and reset value.
    localparam logic [15:0] RISE_SEL_ADDR   = 16'hFF48;
    localparam logic [15:0] FALL_SEL_ADDR   = 16'hFF49;
    localparam logic [7:0]  EDGE_SEL_RESET  = 8'h00;
    localparam int          EXT_PINS        = 3;
    // Status word reset value and flag positions.
    localparam logic [7:0]  PSW_RESET       = 8'h02;
    localparam int          PSW_IE_BIT      = 7;
    localparam int          PSW_ISP_BIT     = 1;
    localparam logic [7:0]  PSW_IMPL_MASK   = 8'hFB;
    // Break vector table entry (low byte address).
    localparam logic [15:0] BRK_VECTOR      = 16'h003E;
    // Request-to-service delays in CPU clocks, and extra wait of low level.
    localparam int          HI_MIN_CLOCKS   = 7;
    localparam int          HI_MAX_CLOCKS   = 32;
    localparam int          LO_MIN_CLOCKS   = 8;
    localparam int          LO_MAX_CLOCKS   = 33;
    localparam int          LO_EXTRA_CLOCKS = LO_MIN_CLOCKS - HI_MIN_CLOCKS;

    // Kind of service being started.
    localparam logic [1:0]  KIND_NMI        = 2'h0;
    localparam logic [1:0]  KIND_MASK       = 2'h1;
    localparam logic [1:0]  KIND_BRK        = 2'h2;

    // Memory manipulation access to the edge select registers.
    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wmask;
        logic [7:0]  wdata;
    } sfr_req_t;

    // Instruction events from the core sequencer, one-cycle strobes.
    typedef struct packed {
        logic insn_done;
        logic ei;
        logic di;
        logic interrupt_return_insn;
        logic break_return_insn;
        logic break_insn;
    } core_cmd_t;

    // Status word write from the core: byte, bit, pop or return restore.
    typedef struct packed {
        logic       we;
        logic [7:0] mask;
        logic [7:0] data;
    } psw_wr_t;

    // Save and vector handshake towards the core.
    typedef struct packed {
        logic busy;
        logic push_psw;
        logic push_pc;
        logic load_vec;
    } seq_out_t;

    // Acceptance sequence states.
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_PRIO = 5'b00010,
        S_PSW  = 5'b00100,
        S_PC   = 5'b01000,
        S_VEC  = 5'b10000
    } seq_state_t;
endpackage

// ### ext_edge_detect.sv
// Valid edge detection for the external interrupt pins.
`timescale 1ns/1ns
module ext_edge_detect
    import irq_accept_pkg::*;
#(
    parameter int N = EXT_PINS
) (
    // Clock, reset and enable.
    input  wire logic         mclk,
    input  wire logic         arst_n,
    input  wire logic         ce,
    // Pins and edge selection.
    input  wire logic [N-1:0] pin,
    input  wire logic [N-1:0] rise_sel,
    input  wire logic [N-1:0] fall_sel,
    // One-cycle pulse per detected valid edge.
    output logic      [N-1:0] edge_pulse
);
    logic [N-1:0] pin_prev_reg;

    // Previous pin level, taken each enabled clock.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pin_prev_reg <= '0;
        end else if (ce) begin
            pin_prev_reg <= pin;
        end
    end

    // Each pin compares its level with the last one; 00 selects no edge.
    for (genvar i = 0; i < N; i++) begin : g_pin
        assign edge_pulse[i] = ce & ((rise_sel[i] & pin[i] & ~pin_prev_reg[i])
                                   | (fall_sel[i] & ~pin[i] & pin_prev_reg[i]));
    end
endmodule // ext_edge_detect

// ### core_model.sv
// Core sequencer model that acknowledges save and vector steps.
`timescale 1ns/1ns
module core_model
    import irq_accept_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Sequence handshake and idle cycles before each answer.
    input  wire seq_out_t    seq,
    input  wire logic [7:0]  push_data,
    input  wire logic [15:0] vector_addr,
    input  wire logic [1:0]  slow,
    output logic             seq_ack,
    // Status byte and vector of the last service, and services done.
    output logic [7:0]       saved_status,
    output logic [15:0]      saved_vec,
    output int               services
);
    logic [1:0] wait_cnt;
    logic       step;
    assign step = seq.push_psw | seq.push_pc | seq.load_vec;
    ////////////////////////////////////////////////////////////////////////////
    // Answers a step after slow idle cycles, moving only at the falling edge.
    always @(negedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            seq_ack  <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (seq_ack || !step) begin
            seq_ack  <= 1'b0;
            wait_cnt <= 2'h0;
        end else if (wait_cnt >= slow) begin
            seq_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 2'h1;
        end
    end
    // Records the status pushed and the vector loaded at their acknowledged steps; the counter push records nothing.
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            services <= 0;
        end else if (seq_ack && seq.push_psw) begin
            saved_status <= push_data;
        end else if (seq_ack && seq.load_vec) begin
            saved_vec <= vector_addr;
            services  <= services + 1;
        end
    end
endmodule // core_model

// ### test_interrupt_accept_control.sv
// Self-checking bench for the interrupt acceptance block.
`timescale 1ns/1ns
module test_interrupt_accept_control;
    import irq_accept_pkg::*;
    localparam logic [5:0] cmd_done = 6'h20, cmd_enable = 6'h10, cmd_disable = 6'h08;
    localparam logic [5:0] cmd_ret = 6'h04, cmd_bret = 6'h02, cmd_soft = 6'h01;
    logic        mclk, arst_n, ce, nmi_event, seq_ack, nmi_in_service;
    logic [2:0]  pin;
    logic [1:0]  slow;
    logic [23:0] src_event, mask_flag, priority_flag, request_flag;
    logic [7:0]  sfr_rdata, status, push_data, saved_status;
    logic [15:0] vector_addr, saved_vec;
    logic [31:0] rng;
    sfr_req_t    sfr;
    core_cmd_t   cmd;
    psw_wr_t     status_wr;
    seq_out_t    seq;
    int          services, failures, comparisons, a, b, w, n;
    irq_accept_ctrl DUT (.mclk(mclk), .arst_n(arst_n), .ce(ce), .ext_irq_pin(pin),
        .src_event(src_event), .mask_flag(mask_flag), .priority_flag(priority_flag),
        .nmi_event(nmi_event), .request_flag(request_flag), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .core_cmd(cmd), .psw_wr(status_wr), .processor_status_word(status),
        .seq_ack(seq_ack), .seq(seq), .push_data(push_data), .vector_addr(vector_addr),
        .nmi_in_service(nmi_in_service));
    core_model partner (.mclk(mclk), .arst_n(arst_n), .seq(seq), .push_data(push_data),
        .vector_addr(vector_addr), .slow(slow), .seq_ack(seq_ack),
        .saved_status(saved_status), .saved_vec(saved_vec), .services(services));
    ////////////////////////////////////////////////////////////////////////////
    // Counts a comparison and reports a mismatch at once.
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic end_sim;
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Next value of the xorshift generator.
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Winner of two requests: high level first, then lower index.
    function automatic int winner(input int i, input int j, input logic pi, input logic pj);
        if (pi != pj) return pi ? j : i;
        return (i < j) ? i : j;
    endfunction
    // One edge select access; read data is settled when the task returns.
    task automatic sfr_acc(input logic [15:0] ad, input logic wr, input logic [7:0] m,
                           input logic [7:0] d);
        sfr = '{ad, wr, ~wr, m, d};
        @(negedge mclk);
        sfr = '0;
        @(negedge mclk);
    endtask
    // One-cycle core command strobe, then one quiet cycle.
    task automatic strobe(input logic [5:0] c);
        cmd = c;
        @(negedge mclk);
        cmd = '0;
        @(negedge mclk);
    endtask
    // One-cycle status word write by the core, then one quiet cycle.
    task automatic wr_status(input logic [7:0] m, input logic [7:0] d);
        status_wr = '{1'b1, m, d};
        @(negedge mclk);
        status_wr = '0;
        @(negedge mclk);
    endtask
    // Waits for one finished service and checks what it saved and where it went.
    task automatic serve(input logic [15:0] vec, input logic [7:0] pushed);
        int k;
        k = services;
        for (int t = 0; t < 100 && services == k; t++) @(negedge mclk);
        @(negedge mclk);
        cmp(16'(services - k), 16'h0001);
        cmp(saved_vec, vec);
        cmp({8'h00, saved_status}, {8'h00, pushed});
    endtask
    // Clock.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Cuts a hang short.
    initial begin
        #200000;
        failures++;
        end_sim;
    end
    // Main sequence.
    initial begin
        {arst_n, nmi_event, pin, slow, src_event} = '0;
        {sfr, cmd, status_wr, failures, comparisons} = '0;
        ce = 1'b1;
        mask_flag = '1;
        priority_flag = '1;
        rng = 32'h000137D9;
        repeat (20) @(negedge mclk);
        arst_n = 1'b1;
        cmp(16'(status), 16'h0002);
        cmp(16'(request_flag), 16'h0000);
        sfr_acc(RISE_SEL_ADDR, 1'b0, 8'h00, 8'h00);
        cmp(16'(sfr_rdata), 16'h0000);
        pin = 3'h7;
        @(negedge mclk);
        pin = 3'h0;
        @(negedge mclk);
        cmp(16'(request_flag[2:0]), 16'h0000);
        sfr_acc(RISE_SEL_ADDR, 1'b1, 8'hFF, 8'hFE);
        sfr_acc(FALL_SEL_ADDR, 1'b1, 8'h07, 8'hFD);
        sfr_acc(RISE_SEL_ADDR, 1'b0, 8'h00, 8'h00);
        cmp(16'(sfr_rdata), 16'h0006);
        sfr_acc(FALL_SEL_ADDR, 1'b0, 8'h00, 8'h00);
        cmp(16'(sfr_rdata), 16'h0005);
        sfr_acc(16'hFF4A, 1'b0, 8'h00, 8'h00);
        cmp(16'(sfr_rdata), 16'h0000);
        pin = 3'h7;
        @(negedge mclk);
        cmp(16'(request_flag[2:0]), 16'h0006);
        pin = 3'h0;
        @(negedge mclk);
        cmp(16'(request_flag[2:0]), 16'h0007);
        strobe(cmd_enable);
        cmp(16'(status), 16'h0082);
        strobe(cmd_disable);
        cmp(16'(status), 16'h0002);
        ce = 1'b0;
        strobe(cmd_enable);
        cmp(16'(status), 16'h0002);
        ce = 1'b1;
        wr_status(8'h02, 8'h00);
        cmp(16'(status), 16'h0000);
        wr_status(8'hFF, 8'hFF);
        cmp(16'(status), 16'h00FB);
        wr_status(8'hFF, 8'h80);
        src_event[6] = 1'b1;
        @(negedge mclk);
        src_event = '0;
        strobe(cmd_done);
        strobe(cmd_done);
        cmp(16'(services), 16'h0000);
        mask_flag[6] = 1'b0;
        strobe(cmd_done);
        strobe(cmd_done);
        cmp(16'(services), 16'h0000);
        cmp(16'(request_flag[6]), 16'h0001);
        wr_status(8'hFF, 8'h82);
        strobe(cmd_done);
        serve(16'h0012, 8'h82);
        cmp(16'(status), 16'h0002);
        cmp(16'(request_flag[6]), 16'h0000);
        for (int i = 0; i < 8; i++) begin
            rng = xs(rng);
            a = int'(rng % 24);
            b = (a + 1 + int'((rng >> 8) % 23)) % 24;
            slow = rng[17:16];
            mask_flag = ~((24'h1 << a) | (24'h1 << b));
            priority_flag = ({23'h0, rng[20]} << a) | ({23'h0, rng[21]} << b);
            w = winner(a, b, rng[20], rng[21]);
            wr_status(8'hFF, 8'h82);
            src_event = (24'h1 << a) | (24'h1 << b);
            @(negedge mclk);
            src_event = '0;
            strobe(cmd_done);
            serve(16'(6 + 2 * w), 8'h82);
            cmp(16'(status), 16'({priority_flag[w], 1'b0}));
            strobe(cmd_ret);
            wr_status(8'hFF, 8'h82);
            strobe(cmd_done);
            strobe(cmd_done);
            serve(16'(6 + 2 * (a + b - w)), 8'h82);
            cmp(16'(request_flag[a] | request_flag[b]), 16'h0000);
            strobe(cmd_ret);
            strobe(cmd_done);
        end
        mask_flag = '1;
        slow = 2'h1;
        wr_status(8'hFF, 8'h82);
        strobe(cmd_disable);
        nmi_event = 1'b1;
        @(negedge mclk);
        nmi_event = 1'b0;
        strobe(cmd_done);
        serve(16'h0004, 8'h02);
        cmp(16'({status, 7'h00, nmi_in_service}), 16'h0001);
        n = services;
        repeat (2) begin
            nmi_event = 1'b1;
            @(negedge mclk);
            nmi_event = 1'b0;
            strobe(cmd_done);
        end
        strobe(cmd_ret);
        wr_status(8'hFF, 8'h02);
        strobe(cmd_done);
        cmp(16'(services), 16'(n));
        strobe(cmd_done);
        serve(16'h0004, 8'h02);
        strobe(cmd_ret);
        repeat (3) strobe(cmd_done);
        cmp(16'(services), 16'(n + 1));
        cmp(16'(nmi_in_service), 16'h0000);
        wr_status(8'hFF, 8'h82);
        strobe(cmd_soft);
        serve(BRK_VECTOR, 8'h82);
        cmp(16'(status), 16'h0002);
        strobe(cmd_bret);
        wr_status(8'hFF, 8'h82);
        cmp(16'(status), 16'h0082);
        end_sim;
    end
endmodule // test_interrupt_accept_control
